// [sld_pkg.sv]
package sld_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ = 25_000_000;
    localparam int unsigned DEBOUNCE_MS = 20;
    localparam int unsigned DEBOUNCE_CYC = SYS_CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int unsigned DBC_W = 20;
    localparam int unsigned PREC_OSC_HZ = 32768;
    localparam int unsigned BP_HZ = 100;
    localparam int unsigned BP_HALF_TICKS = PREC_OSC_HZ / (2 * BP_HZ);
    localparam int unsigned TEST_HZ = 1;
    localparam int unsigned TEST_HALF_TICKS = PREC_OSC_HZ / (2 * TEST_HZ);
    localparam int unsigned DIV_W = 15;
    localparam int unsigned STEP_HALVES = 25;
    localparam int unsigned STEP_W = 6;

    // ------------------------------------------------------------
    // Display layout and reset values
    // ------------------------------------------------------------
    localparam int unsigned LOGO_W = 8;
    localparam int unsigned GFX_N = 4;
    localparam logic SEL_PREC = 1'b0;
    localparam logic BP_RESET = 1'b0;

    typedef enum logic [1:0] {
        SLD_BLANK,
        SLD_SCROLL,
        SLD_GRAPHICS
    } sld_state_t;

    typedef struct packed {
        logic backplane_drive;
        logic [LOGO_W-1:0] logo_segment;
        logic family_logo_segment;
        logic high_speed_segment;
        logic low_power_segment;
        logic lightning_segment;
        logic aux_digit_segment_a;
        logic aux_digit_segment_b;
    } sld_lcd_t;

    typedef struct packed {
        logic one_hz_out;
        logic plain_copy;
        logic hyst_copy;
    } sld_hdr_t;

endpackage : sld_pkg

// [sld_driver.sv]
`timescale 1ns/100ps

module sld_driver #(
    parameter int unsigned DEBOUNCE_CYCLES = sld_pkg::DEBOUNCE_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic prec_osc_in,
    input wire logic rc_osc_in,
    input wire logic reset_button_n,
    input wire logic clock_select_button_n,
    input wire logic plain_in,
    input wire logic hyst_in,
    output sld_pkg::sld_lcd_t lcd,
    output sld_pkg::sld_hdr_t test_header,
    output logic rc_selected
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] prec_sync;
    logic [2:0] rc_sync;
    logic [1:0] btn_sync [2];
    logic [1:0] btn_level;
    logic [1:0] btn_prev;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prec_sync <= 3'h0;
            rc_sync <= 3'h0;
            btn_sync[0] <= 2'h0;
            btn_sync[1] <= 2'h0;
            btn_prev <= 2'h0;
        end
        else
        begin
            prec_sync <= {prec_sync[1:0], prec_osc_in};
            rc_sync <= {rc_sync[1:0], rc_osc_in};
            btn_sync[0] <= {btn_sync[0][0], ~reset_button_n};
            btn_sync[1] <= {btn_sync[1][0], ~clock_select_button_n};
            btn_prev <= btn_level;
        end
    end

    // ------------------------------------------------------------
    // Button debounce
    // ------------------------------------------------------------
    // A level must stay put for the whole debounce window before it is
    // accepted, so contact bounce shorter than the window cannot yield a second action.
    for (genvar b = 0; b < 2; b++)
    begin : g_dbc
        logic [sld_pkg::DBC_W-1:0] cnt;
        logic [sld_pkg::DBC_W-1:0] next_cnt;
        logic next_level;

        always_comb
        begin
            next_cnt = '0;
            next_level = btn_level[b];
            if (btn_sync[b][1] != btn_level[b])
            begin
                if (cnt == sld_pkg::DBC_W'(DEBOUNCE_CYCLES - 1))
                begin
                    next_level = btn_sync[b][1];
                end
                else
                begin
                    next_cnt = cnt + 1'b1;
                end
            end
        end

        always_ff @(posedge sys_clk or negedge rstn)
        begin
            if (!rstn)
            begin
                cnt <= '0;
                btn_level[b] <= 1'b0;
            end
            else
            begin
                cnt <= next_cnt;
                btn_level[b] <= next_level;
            end
        end
    end

    // ------------------------------------------------------------
    // Timing, clock selection and sequencer
    // ------------------------------------------------------------
    logic sel;
    logic sel_pending;
    logic bp;
    logic one_hz;
    logic slow_phase;
    logic [sld_pkg::DIV_W-1:0] bp_cnt;
    logic [sld_pkg::DIV_W-1:0] hz_cnt;
    logic [sld_pkg::STEP_W-1:0] step_cnt;
    logic [2:0] pos;
    sld_pkg::sld_state_t state;

    logic next_sel;
    logic next_sel_pending;
    logic next_bp;
    logic next_one_hz;
    logic next_slow_phase;
    logic [sld_pkg::DIV_W-1:0] next_bp_cnt;
    logic [sld_pkg::DIV_W-1:0] next_hz_cnt;
    logic [sld_pkg::STEP_W-1:0] next_step_cnt;
    logic [2:0] next_pos;
    sld_pkg::sld_state_t next_state;
    sld_pkg::sld_lcd_t next_lcd;
    sld_pkg::sld_hdr_t next_hdr;

    logic tick;
    logic half_wrap;
    logic advance;
    logic soft_rst;
    logic [sld_pkg::LOGO_W-1:0] logo_on;
    logic [sld_pkg::GFX_N-1:0] gfx_on;

    always_comb
    begin
        soft_rst = btn_level[0];
        tick = sel ? (rc_sync[1] & ~rc_sync[2]) : (prec_sync[1] & ~prec_sync[2]);
        next_sel = sel;
        next_sel_pending = sel_pending;
        next_bp = bp;
        next_one_hz = one_hz;
        next_slow_phase = slow_phase;
        next_bp_cnt = bp_cnt;
        next_hz_cnt = hz_cnt;
        next_step_cnt = step_cnt;
        next_pos = pos;
        next_state = state;
        half_wrap = 1'b0;
        advance = 1'b0;

        if (tick)
        begin
            if (bp_cnt == sld_pkg::DIV_W'(sld_pkg::BP_HALF_TICKS - 1))
            begin
                next_bp_cnt = '0;
                next_bp = ~bp;
                half_wrap = 1'b1;
            end
            else
            begin
                next_bp_cnt = bp_cnt + 1'b1;
            end
            if (hz_cnt == sld_pkg::DIV_W'(sld_pkg::TEST_HALF_TICKS - 1))
            begin
                next_hz_cnt = '0;
                next_one_hz = ~one_hz;
            end
            else
            begin
                next_hz_cnt = hz_cnt + 1'b1;
            end
        end

        // switch at boundary
        // Clock-select swaps happen only at a half-period boundary, keeping those backplane half periods
        // whole; a button reset forces SEL_PREC at once, mid-half. The first half after such a swap runs on the new source.
        if (half_wrap && sel_pending)
        begin
            next_sel = ~sel;
            next_sel_pending = 1'b0;
        end
        if (btn_level[1] && !btn_prev[1])
        begin
            next_sel_pending = ~next_sel_pending;
        end

        if (half_wrap)
        begin
            if (step_cnt == sld_pkg::STEP_W'(sld_pkg::STEP_HALVES - 1))
            begin
                next_step_cnt = '0;
                if (sel && !slow_phase)
                begin
                    next_slow_phase = 1'b1;
                end
                else
                begin
                    next_slow_phase = 1'b0;
                    advance = 1'b1;
                end
            end
            else
            begin
                next_step_cnt = step_cnt + 1'b1;
            end
        end

        case (state)
            sld_pkg::SLD_BLANK:
            begin
                next_state = sld_pkg::SLD_SCROLL;
                next_pos = 3'h0;
            end
            sld_pkg::SLD_SCROLL:
            begin
                if (advance)
                begin
                    if (pos == 3'(sld_pkg::LOGO_W - 1))
                    begin
                        next_state = sld_pkg::SLD_GRAPHICS;
                        next_pos = 3'h0;
                    end
                    else
                    begin
                        next_pos = pos + 3'h1;
                    end
                end
            end
            sld_pkg::SLD_GRAPHICS:
            begin
                if (advance)
                begin
                    if (pos == 3'(sld_pkg::GFX_N - 1))
                    begin
                        next_state = sld_pkg::SLD_SCROLL;
                        next_pos = 3'h0;
                    end
                    else
                    begin
                        next_pos = pos + 3'h1;
                    end
                end
            end
            default:
            begin
                next_state = sld_pkg::SLD_BLANK;
            end
        endcase

        if (soft_rst)
        begin
            next_state = sld_pkg::SLD_BLANK;
            next_pos = 3'h0;
            next_step_cnt = '0;
            next_slow_phase = 1'b0;
            next_sel = sld_pkg::SEL_PREC;
            next_sel_pending = 1'b0;
        end

        logo_on = '0;
        gfx_on = '0;
        if (next_state == sld_pkg::SLD_SCROLL)
        begin
            logo_on = sld_pkg::LOGO_W'(1) << next_pos;
        end
        if (next_state == sld_pkg::SLD_GRAPHICS)
        begin
            gfx_on = sld_pkg::GFX_N'(1) << next_pos[1:0];
        end

        next_lcd.backplane_drive = next_bp;
        next_lcd.logo_segment = {sld_pkg::LOGO_W{next_bp}} ^ logo_on;
        next_lcd.family_logo_segment = next_bp ^ gfx_on[0];
        next_lcd.high_speed_segment = next_bp ^ gfx_on[1];
        next_lcd.low_power_segment = next_bp ^ gfx_on[2];
        next_lcd.lightning_segment = next_bp ^ gfx_on[3];
        next_lcd.aux_digit_segment_a = next_bp;
        next_lcd.aux_digit_segment_b = next_bp;

        next_hdr.one_hz_out = next_one_hz;
        next_hdr.plain_copy = plain_in;
        next_hdr.hyst_copy = hyst_in;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sel <= sld_pkg::SEL_PREC;
            sel_pending <= 1'b0;
            bp <= sld_pkg::BP_RESET;
            one_hz <= 1'b0;
            slow_phase <= 1'b0;
            bp_cnt <= '0;
            hz_cnt <= '0;
            step_cnt <= '0;
            pos <= 3'h0;
            state <= sld_pkg::SLD_BLANK;
            lcd <= '0;
            test_header <= '0;
            rc_selected <= sld_pkg::SEL_PREC;
        end
        else
        begin
            sel <= next_sel;
            sel_pending <= next_sel_pending;
            bp <= next_bp;
            one_hz <= next_one_hz;
            slow_phase <= next_slow_phase;
            bp_cnt <= next_bp_cnt;
            hz_cnt <= next_hz_cnt;
            step_cnt <= next_step_cnt;
            pos <= next_pos;
            state <= next_state;
            lcd <= next_lcd;
            test_header <= next_hdr;
            rc_selected <= next_sel;
        end
    end

endmodule : sld_driver

// [sld_driver_properties.sv]
`timescale 1ns/100ps
module sld_driver_checker #(
    parameter int unsigned DEBOUNCE_CYCLES = 8
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic prec_osc_in,
    input wire logic rc_osc_in,
    input wire logic reset_button_n,
    input wire logic clock_select_button_n,
    input wire logic plain_in,
    input wire logic hyst_in,
    input wire sld_pkg::sld_lcd_t lcd,
    input wire sld_pkg::sld_hdr_t test_header,
    input wire logic rc_selected
);
    // --------------------------------
    // Helper counters
    // --------------------------------
    logic [11:0] lit;
    logic [31:0] held;
    logic [31:0] next_held;
    logic [15:0] run;
    logic [15:0] next_run;
    logic bp_prev;
    logic next_bp_prev;
    assign lit = {lcd.lightning_segment, lcd.low_power_segment, lcd.high_speed_segment,
        lcd.family_logo_segment, lcd.logo_segment} ^ {12{lcd.backplane_drive}};
    always_comb
    begin
        next_held = reset_button_n ? 32'h0 : held + 32'h1;
        next_run = (lcd.backplane_drive != bp_prev) ? 16'h0 : run + 16'h1;
        next_bp_prev = lcd.backplane_drive;
    end
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            held <= 32'h0;
            run <= 16'h0;
            bp_prev <= 1'h0;
        end
        else
        begin
            held <= next_held;
            run <= next_run;
            bp_prev <= next_bp_prev;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    plain_copy_a: assert property ($past(rstn) |-> test_header.plain_copy == $past(plain_in))
        else $error("plain copy wrong");
    hyst_copy_a: assert property ($past(rstn) |-> test_header.hyst_copy == $past(hyst_in))
        else $error("hysteresis copy wrong");
    aux_dark_a: assert property (lcd.aux_digit_segment_a == lcd.backplane_drive
        && lcd.aux_digit_segment_b == lcd.backplane_drive) else $error("aux segment lit");
    one_lit_a: assert property ($onehot0(lit)) else $error("more than one segment lit");
    held_blank_a: assert property (held > DEBOUNCE_CYCLES + 6 |-> lit == 12'h000)
        else $error("segment lit while reset held");
    held_prec_a: assert property (held > DEBOUNCE_CYCLES + 6 |-> !rc_selected)
        else $error("rc selected while reset held");
    bp_min_half_a: assert property ($changed(lcd.backplane_drive) |-> run >= 16'h384)
        else $error("backplane half too short");
    bp_steady_a: assert property (run < 16'hFA0) else $error("backplane stopped");
    switch_wrap_a: assert property ($rose(rc_selected) |-> $changed(lcd.backplane_drive))
        else $error("source switched off boundary");
    reset_prec_a: assert property ($rose(rstn) |-> !rc_selected [*8])
        else $error("rc selected after reset");
endmodule : sld_driver_checker
bind sld_driver sld_driver_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) sld_driver_checker_inst (
    .sys_clk(sys_clk), .rstn(rstn), .prec_osc_in(prec_osc_in), .rc_osc_in(rc_osc_in),
    .reset_button_n(reset_button_n), .clock_select_button_n(clock_select_button_n),
    .plain_in(plain_in), .hyst_in(hyst_in), .lcd(lcd), .test_header(test_header),
    .rc_selected(rc_selected));

// [sld_glass_model.sv]
`timescale 1ns/100ps
module sld_glass_model #(
    parameter int PREC_HALF = 3,
    parameter int RC_HALF = 5
) (
    input wire logic sys_clk,
    input wire sld_pkg::sld_lcd_t lcd,
    output logic prec_osc_in,
    output logic rc_osc_in,
    output logic [11:0] lit
);
    // --------------------------------
    // Oscillators and glass
    // --------------------------------
    int pc = 0;
    int rcc = 0;
    initial prec_osc_in = 1'b0;
    initial rc_osc_in = 1'b0;
    // Both oscillators run free; they are scaled far above real rates to keep the run short.
    always @(negedge sys_clk)
    begin
        pc = (pc + 1) % PREC_HALF;
        rcc = (rcc + 1) % RC_HALF;
        if (pc == 0) prec_osc_in = ~prec_osc_in;
        if (rcc == 0) rc_osc_in = ~rc_osc_in;
    end
    assign lit = {lcd.lightning_segment, lcd.low_power_segment, lcd.high_speed_segment,
        lcd.family_logo_segment, lcd.logo_segment} ^ {12{lcd.backplane_drive}};
endmodule : sld_glass_model

// [test_segment_lcd_demo_driver.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin mismatches++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module test_segment_lcd_demo_driver;
    // --------------------------------
    // Bench
    // --------------------------------
    localparam int PH = 3;
    localparam int RH = 5;
    logic sys_clk, rstn, prec, rc, rst_b_n, sel_b_n, plain_in, hyst_in, rc_selected;
    logic [11:0] lit;
    sld_pkg::sld_lcd_t lcd;
    sld_pkg::sld_hdr_t hdr;
    int mismatches = 0;
    int n_checks = 0;
    int n;
    sld_driver #(.DEBOUNCE_CYCLES(8)) sld_driver_inst (.sys_clk(sys_clk), .rstn(rstn),
        .prec_osc_in(prec), .rc_osc_in(rc), .reset_button_n(rst_b_n),
        .clock_select_button_n(sel_b_n), .plain_in(plain_in), .hyst_in(hyst_in),
        .lcd(lcd), .test_header(hdr), .rc_selected(rc_selected));
    sld_glass_model #(.PREC_HALF(PH), .RC_HALF(RH)) sld_glass_model_inst (.sys_clk(sys_clk),
        .lcd(lcd), .prec_osc_in(prec), .rc_osc_in(rc), .lit(lit));
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : cyc
    // Counts cycles until the backplane next changes level.
    task automatic wait_bp(output int c);
        logic b;
        b = lcd.backplane_drive;
        c = 0;
        while (lcd.backplane_drive === b && c < 4000)
        begin
            cyc(1);
            c++;
        end
        `CHK("bp_run", 1'b1, c < 4000)
    endtask : wait_bp
    task automatic t_copies;
        for (int i = 0; i < 4; i++)
        begin
            {plain_in, hyst_in} = i[1:0];
            cyc(2);
            `CHK("plain", i[1], hdr.plain_copy)
            `CHK("hyst", i[0], hdr.hyst_copy)
        end
        $display("t_copies done");
    endtask : t_copies
    task automatic t_backplane;
        `CHK("rc_sel", 1'b0, rc_selected)
        wait_bp(n);
        wait_bp(n);
        `CHK("bp_half", sld_pkg::BP_HALF_TICKS * 2 * PH, n)
        `CHK("lit", 12'h001, lit)
        n = 0;
        while (lit === 12'h001 && n < 30000)
        begin
            cyc(1);
            n++;
        end
        `CHK("scroll", 12'h002, lit)
        $display("t_backplane done");
    endtask : t_backplane
    task automatic t_toggle;
        sel_b_n = 1'b0;
        cyc(3);
        sel_b_n = 1'b1;
        wait_bp(n);
        wait_bp(n);
        `CHK("bounce", 1'b0, rc_selected)
        sel_b_n = 1'b0;
        cyc(20);
        sel_b_n = 1'b1;
        n = 0;
        while (rc_selected !== 1'b1 && n < 4000)
        begin
            cyc(1);
            n++;
        end
        wait_bp(n);
        wait_bp(n);
        `CHK("toggle", 1'b1, rc_selected)
        `CHK("rc_half", sld_pkg::BP_HALF_TICKS * 2 * RH, n)
        $display("t_toggle done");
    endtask : t_toggle
    task automatic t_button_reset;
        rst_b_n = 1'b0;
        cyc(30);
        `CHK("held_lit", 12'h000, lit)
        `CHK("held_sel", 1'b0, rc_selected)
        rst_b_n = 1'b1;
        cyc(20);
        `CHK("restart", 12'h001, lit)
        $display("t_button_reset done");
    endtask : t_button_reset
    // The button reset cleared the step count, so an unslowed sequencer would
    // advance at the 25th wrap; with the slow source it must still stand at 0.
    task automatic t_slow_rc;
        sel_b_n = 1'b0;
        cyc(20);
        sel_b_n = 1'b1;
        for (int i = 0; i < 26; i++)
        begin
            wait_bp(n);
        end
        `CHK("slow_sel", 1'b1, rc_selected)
        `CHK("slow_step", 12'h001, lit)
        `CHK("one_hz", 1'b0, hdr.one_hz_out)
        $display("t_slow_rc done");
    endtask : t_slow_rc
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial
    begin
        {rstn, plain_in, hyst_in} = 3'h0;
        {rst_b_n, sel_b_n} = 2'h3;
        cyc(10);
        rstn = 1'b1;
        t_copies();
        t_backplane();
        t_toggle();
        t_button_reset();
        t_slow_rc();
        summarize();
    end
    initial
    begin
        cyc(100000);
        mismatches++;
        $display("watchdog expired");
        summarize();
    end
endmodule : test_segment_lcd_demo_driver
